// ==== iep_map.vh ====
// register map, field positions and reset values of the interrupt enable and priority bank
// Contract
// - global gate clear blocks every source
// - global gate set passes individually masked sources
// - primary bit 6 gates SPI port
// - primary bit 5 gates timer 2 overflows
// - primary bit 4 gates UART
// - primary bit 3 gates timer 1 overflow
// - primary bit 2 gates external input B
// - primary bit 1 gates timer 0 overflow
// - primary bit 0 gates external input A
// - primary level bit 7 reads one, ignores writes
// - primary level bits select high priority
// - extended bit 7 gates timer 3 overflows
// - extended bit 6 gates comparator B flags
// - extended bit 5 gates comparator A flags
// - extended bit 4 gates counter array
// - extended bit 3 gates conversion done
// - extended bit 2 gates window compare
// - extended bit 1 gates USB function
// - extended bit 0 gates two-wire port
// - extended level bits select high priority
// - second extended bits 7-1 read zero
// - second extended bit 0 gates supply sense
// - high preempts low, nothing preempts high
// - same level resolved lowest source first
// - requests resolved every clock cycle with ce_i high
`ifndef IEP_MAP_VH
`define IEP_MAP_VH

`define IEP_ADDR_GATE_PRI 8'hA8
`define IEP_ADDR_LEVEL_PRI 8'hB8
`define IEP_ADDR_GATE_EXT1 8'hE6
`define IEP_ADDR_GATE_EXT2 8'hE7
`define IEP_ADDR_LEVEL_EXT1 8'hF6
`define IEP_ADDR_LEVEL_EXT2 8'hF7

`define IEP_BITBASE_GATE_PRI 5'h15
`define IEP_BITBASE_LEVEL_PRI 5'h17

`define IEP_RST_GATE_PRI 8'h00
`define IEP_RST_LEVEL_PRI 8'h80
`define IEP_RST_GATE_EXT1 8'h00
`define IEP_RST_GATE_EXT2 8'h00
`define IEP_RST_LEVEL_EXT1 8'h00
`define IEP_RST_LEVEL_EXT2 8'h00
`define IEP_UNMAPPED_READ 8'h00

`define IEP_LEVEL_PRI_FIXED 8'h80
`define IEP_EXT2_IMPL_MASK 8'h01

`define IEP_BIT_GLOBAL 7
`define IEP_BIT_SPI 6
`define IEP_BIT_TIMER2 5
`define IEP_BIT_UART 4
`define IEP_BIT_TIMER1 3
`define IEP_BIT_EXT_B 2
`define IEP_BIT_TIMER0 1
`define IEP_BIT_EXT_A 0

`define IEP_BIT_TIMER3 7
`define IEP_BIT_CMP_B 6
`define IEP_BIT_CMP_A 5
`define IEP_BIT_PCA 4
`define IEP_BIT_CONV 3
`define IEP_BIT_WINDOW 2
`define IEP_BIT_USB 1
`define IEP_BIT_TWO_WIRE 0
`define IEP_BIT_SUPPLY 0

`define IEP_NUM_SRC 16
`define IEP_VEC_W 4

`define IEP_SRC_EXT_A 0
`define IEP_SRC_TIMER0 1
`define IEP_SRC_EXT_B 2
`define IEP_SRC_TIMER1 3
`define IEP_SRC_UART 4
`define IEP_SRC_TIMER2 5
`define IEP_SRC_SPI 6
`define IEP_SRC_TWO_WIRE 7
`define IEP_SRC_USB 8
`define IEP_SRC_WINDOW 9
`define IEP_SRC_CONV 10
`define IEP_SRC_PCA 11
`define IEP_SRC_CMP_A 12
`define IEP_SRC_CMP_B 13
`define IEP_SRC_TIMER3 14
`define IEP_SRC_SUPPLY 15

`endif

// ==== iep_pick.v ====
// fixed-order picker: finds the lowest set request bit
`timescale 1ns/10ps
module iep_pick #(
    parameter WIDTH = 16,
    parameter IDXW = 4
) (
    input wire [WIDTH-1:0] req_i,
    output reg found_o,
    output reg [IDXW-1:0] index_o
);
    integer i;

    // scan downward so the lowest index is the last to win
    always @* begin
        found_o = 1'b0;
        index_o = {IDXW{1'b0}};
        for (i = WIDTH - 1; i >= 0; i = i - 1) begin
            if (req_i[i]) begin
                found_o = 1'b1;
                index_o = i[IDXW-1:0];
            end
        end
    end
endmodule // iep_pick

// ==== iep_irq_regs.v ====
// interrupt enable and priority register bank with level arbitration
`timescale 1ns/10ps
`include "iep_map.vh"
module iep_irq_regs (
    input wire clk_sys_i,
    input wire rst_i,
    input wire ce_i,
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire [7:0] sfr_wdata_i,
    input wire sfr_rd_i,
    output reg [7:0] sfr_rdata_o,
    input wire [7:0] bit_addr_i,
    input wire bit_wr_i,
    input wire bit_wdata_i,
    input wire bit_rd_i,
    output reg bit_rdata_o,
    input wire ext_in_a_i,
    input wire timer0_overflow_i,
    input wire ext_in_b_i,
    input wire timer1_overflow_i,
    input wire uart_req_i,
    input wire timer2_low_overflow_i,
    input wire timer2_high_overflow_i,
    input wire spi_port_req_i,
    input wire two_wire_req_i,
    input wire usb_function_req_i,
    input wire window_cmp_flag_i,
    input wire conv_done_flag_i,
    input wire counter_array_req_i,
    input wire comparator_a_rise_flag_i,
    input wire comparator_a_fall_flag_i,
    input wire comparator_b_rise_flag_i,
    input wire comparator_b_fall_flag_i,
    input wire timer3_low_overflow_i,
    input wire timer3_high_overflow_i,
    input wire supply_sense_i,
    input wire irq_ack_i,
    input wire irq_return_i,
    output reg irq_req_o,
    output reg [3:0] irq_vector_o,
    output reg irq_level_o,
    output reg in_service_low_o,
    output reg in_service_high_o
);
    reg [7:0] source_gate_primary;
    reg [7:0] level_select_primary;
    reg [7:0] source_gate_ext_one;
    reg [7:0] source_gate_ext_two;
    reg [7:0] level_select_ext_one;
    reg [7:0] level_select_ext_two;

    reg [7:0] next_rdata;
    reg next_bit_rdata;
    reg next_req;
    reg [3:0] next_vector;
    reg next_level;
    reg next_in_low;
    reg next_in_high;

    wire [15:0] src_req;
    wire [15:0] armed;
    wire [15:0] level_bits;
    wire [15:0] high_req;
    wire [15:0] low_req;
    wire high_found;
    wire low_found;
    wire [3:0] high_index;
    wire [3:0] low_index;

    wire global_irq_gate;
    wire spi_port_mask;
    wire timer2_mask;
    wire uart_mask;
    wire timer1_mask;
    wire ext_in_b_mask;
    wire timer0_mask;
    wire ext_in_a_mask;
    wire timer3_mask;
    wire comparator_b_mask;
    wire comparator_a_mask;
    wire counter_array_mask;
    wire conv_done_mask;
    wire window_cmp_mask;
    wire usb_function_mask;
    wire two_wire_mask;
    wire supply_sense_mask;

    wire byte_wr_gate_pri;
    wire byte_wr_level_pri;
    wire bit_wr_gate_pri;
    wire bit_wr_level_pri;
    wire [7:0] bit_onehot;

    assign global_irq_gate = source_gate_primary[`IEP_BIT_GLOBAL];
    assign spi_port_mask = source_gate_primary[`IEP_BIT_SPI];
    assign timer2_mask = source_gate_primary[`IEP_BIT_TIMER2];
    assign uart_mask = source_gate_primary[`IEP_BIT_UART];
    assign timer1_mask = source_gate_primary[`IEP_BIT_TIMER1];
    assign ext_in_b_mask = source_gate_primary[`IEP_BIT_EXT_B];
    assign timer0_mask = source_gate_primary[`IEP_BIT_TIMER0];
    assign ext_in_a_mask = source_gate_primary[`IEP_BIT_EXT_A];
    assign timer3_mask = source_gate_ext_one[`IEP_BIT_TIMER3];
    assign comparator_b_mask = source_gate_ext_one[`IEP_BIT_CMP_B];
    assign comparator_a_mask = source_gate_ext_one[`IEP_BIT_CMP_A];
    assign counter_array_mask = source_gate_ext_one[`IEP_BIT_PCA];
    assign conv_done_mask = source_gate_ext_one[`IEP_BIT_CONV];
    assign window_cmp_mask = source_gate_ext_one[`IEP_BIT_WINDOW];
    assign usb_function_mask = source_gate_ext_one[`IEP_BIT_USB];
    assign two_wire_mask = source_gate_ext_one[`IEP_BIT_TWO_WIRE];
    assign supply_sense_mask = source_gate_ext_two[`IEP_BIT_SUPPLY];

    // raw requests in vector order; two-flag sources are ored here
    assign src_req[`IEP_SRC_EXT_A] = ext_in_a_i;
    assign src_req[`IEP_SRC_TIMER0] = timer0_overflow_i;
    assign src_req[`IEP_SRC_EXT_B] = ext_in_b_i;
    assign src_req[`IEP_SRC_TIMER1] = timer1_overflow_i;
    assign src_req[`IEP_SRC_UART] = uart_req_i;
    assign src_req[`IEP_SRC_TIMER2] = timer2_low_overflow_i | timer2_high_overflow_i;
    assign src_req[`IEP_SRC_SPI] = spi_port_req_i;
    assign src_req[`IEP_SRC_TWO_WIRE] = two_wire_req_i;
    assign src_req[`IEP_SRC_USB] = usb_function_req_i;
    assign src_req[`IEP_SRC_WINDOW] = window_cmp_flag_i;
    assign src_req[`IEP_SRC_CONV] = conv_done_flag_i;
    assign src_req[`IEP_SRC_PCA] = counter_array_req_i;
    assign src_req[`IEP_SRC_CMP_A] = comparator_a_rise_flag_i
        | comparator_a_fall_flag_i;
    assign src_req[`IEP_SRC_CMP_B] = comparator_b_rise_flag_i
        | comparator_b_fall_flag_i;
    assign src_req[`IEP_SRC_TIMER3] = timer3_low_overflow_i | timer3_high_overflow_i;
    assign src_req[`IEP_SRC_SUPPLY] = supply_sense_i;

    // per-source mask under the global gate
    assign armed[`IEP_SRC_EXT_A] = global_irq_gate & ext_in_a_mask & src_req[0];
    assign armed[`IEP_SRC_TIMER0] = global_irq_gate & timer0_mask & src_req[1];
    assign armed[`IEP_SRC_EXT_B] = global_irq_gate & ext_in_b_mask & src_req[2];
    assign armed[`IEP_SRC_TIMER1] = global_irq_gate & timer1_mask & src_req[3];
    assign armed[`IEP_SRC_UART] = global_irq_gate & uart_mask & src_req[4];
    assign armed[`IEP_SRC_TIMER2] = global_irq_gate & timer2_mask & src_req[5];
    assign armed[`IEP_SRC_SPI] = global_irq_gate & spi_port_mask & src_req[6];
    assign armed[`IEP_SRC_TWO_WIRE] = global_irq_gate & two_wire_mask & src_req[7];
    assign armed[`IEP_SRC_USB] = global_irq_gate & usb_function_mask & src_req[8];
    assign armed[`IEP_SRC_WINDOW] = global_irq_gate & window_cmp_mask & src_req[9];
    assign armed[`IEP_SRC_CONV] = global_irq_gate & conv_done_mask & src_req[10];
    assign armed[`IEP_SRC_PCA] = global_irq_gate & counter_array_mask & src_req[11];
    assign armed[`IEP_SRC_CMP_A] = global_irq_gate & comparator_a_mask & src_req[12];
    assign armed[`IEP_SRC_CMP_B] = global_irq_gate & comparator_b_mask & src_req[13];
    assign armed[`IEP_SRC_TIMER3] = global_irq_gate & timer3_mask & src_req[14];
    assign armed[`IEP_SRC_SUPPLY] = global_irq_gate & supply_sense_mask & src_req[15];

    // level map lines up with the vector order bit for bit
    assign level_bits = {level_select_ext_two[`IEP_BIT_SUPPLY], level_select_ext_one,
                         level_select_primary[6:0]};
    assign high_req = armed & level_bits;
    assign low_req = armed & ~level_bits;

    iep_pick #(
        .WIDTH(`IEP_NUM_SRC),
        .IDXW(`IEP_VEC_W)
    ) u_pick_high (
        .req_i(high_req),
        .found_o(high_found),
        .index_o(high_index)
    );

    iep_pick #(
        .WIDTH(`IEP_NUM_SRC),
        .IDXW(`IEP_VEC_W)
    ) u_pick_low (
        .req_i(low_req),
        .found_o(low_found),
        .index_o(low_index)
    );

    // arbitration and preemption, re-resolved on every enabled edge
    always @* begin
        next_req = 1'b0;
        next_vector = 4'h0;
        next_level = 1'b0;
        if (in_service_high_o) begin
            next_req = 1'b0;
        end else if (high_found) begin
            next_req = 1'b1;
            next_vector = high_index;
            next_level = 1'b1;
        end else if (low_found && !in_service_low_o) begin
            next_req = 1'b1;
            next_vector = low_index;
            next_level = 1'b0;
        end
    end

    // in-service tracking; a return closes the newest level, an ack opens one
    always @* begin
        next_in_low = in_service_low_o;
        next_in_high = in_service_high_o;
        if (irq_return_i) begin
            if (in_service_high_o) begin
                next_in_high = 1'b0;
            end else begin
                next_in_low = 1'b0;
            end
        end
        // ack only counts while a request is actually on offer
        if (irq_ack_i && irq_req_o) begin
            if (irq_level_o) begin
                next_in_high = 1'b1;
            end else begin
                next_in_low = 1'b1;
            end
        end
    end

    assign byte_wr_gate_pri = sfr_wr_i && (sfr_addr_i == `IEP_ADDR_GATE_PRI);
    assign byte_wr_level_pri = sfr_wr_i && (sfr_addr_i == `IEP_ADDR_LEVEL_PRI);
    assign bit_wr_gate_pri = bit_wr_i && (bit_addr_i[7:3] == `IEP_BITBASE_GATE_PRI);
    assign bit_wr_level_pri = bit_wr_i && (bit_addr_i[7:3] == `IEP_BITBASE_LEVEL_PRI);
    assign bit_onehot = 8'h01 << bit_addr_i[2:0];

    // register writes; a byte write wins over a bit write in the same cycle
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            source_gate_primary <= `IEP_RST_GATE_PRI;
            level_select_primary <= `IEP_RST_LEVEL_PRI;
            source_gate_ext_one <= `IEP_RST_GATE_EXT1;
            source_gate_ext_two <= `IEP_RST_GATE_EXT2;
            level_select_ext_one <= `IEP_RST_LEVEL_EXT1;
            level_select_ext_two <= `IEP_RST_LEVEL_EXT2;
        end else if (ce_i) begin
            if (byte_wr_gate_pri) begin
                source_gate_primary <= sfr_wdata_i;
            end else if (bit_wr_gate_pri) begin
                if (bit_wdata_i) begin
                    source_gate_primary <= source_gate_primary | bit_onehot;
                end else begin
                    source_gate_primary <= source_gate_primary & ~bit_onehot;
                end
            end
            // top bit of the primary level register is hard-wired high
            if (byte_wr_level_pri) begin
                level_select_primary <= sfr_wdata_i | `IEP_LEVEL_PRI_FIXED;
            end else if (bit_wr_level_pri) begin
                if (bit_wdata_i) begin
                    level_select_primary <= level_select_primary | bit_onehot;
                end else begin
                    level_select_primary <= (level_select_primary & ~bit_onehot)
                                            | `IEP_LEVEL_PRI_FIXED;
                end
            end
            if (sfr_wr_i && (sfr_addr_i == `IEP_ADDR_GATE_EXT1)) begin
                source_gate_ext_one <= sfr_wdata_i;
            end
            if (sfr_wr_i && (sfr_addr_i == `IEP_ADDR_GATE_EXT2)) begin
                source_gate_ext_two <= sfr_wdata_i & `IEP_EXT2_IMPL_MASK;
            end
            if (sfr_wr_i && (sfr_addr_i == `IEP_ADDR_LEVEL_EXT1)) begin
                level_select_ext_one <= sfr_wdata_i;
            end
            if (sfr_wr_i && (sfr_addr_i == `IEP_ADDR_LEVEL_EXT2)) begin
                level_select_ext_two <= sfr_wdata_i & `IEP_EXT2_IMPL_MASK;
            end
        end
    end

    // read mux; unmapped addresses answer zero
    always @* begin
        next_rdata = `IEP_UNMAPPED_READ;
        case (sfr_addr_i)
            `IEP_ADDR_GATE_PRI: begin
                next_rdata = source_gate_primary;
            end
            `IEP_ADDR_LEVEL_PRI: begin
                next_rdata = level_select_primary | `IEP_LEVEL_PRI_FIXED;
            end
            `IEP_ADDR_GATE_EXT1: begin
                next_rdata = source_gate_ext_one;
            end
            `IEP_ADDR_GATE_EXT2: begin
                next_rdata = source_gate_ext_two & `IEP_EXT2_IMPL_MASK;
            end
            `IEP_ADDR_LEVEL_EXT1: begin
                next_rdata = level_select_ext_one;
            end
            `IEP_ADDR_LEVEL_EXT2: begin
                next_rdata = level_select_ext_two & `IEP_EXT2_IMPL_MASK;
            end
            default: begin
                next_rdata = `IEP_UNMAPPED_READ;
            end
        endcase
    end

    always @* begin
        next_bit_rdata = 1'b0;
        if (bit_addr_i[7:3] == `IEP_BITBASE_GATE_PRI) begin
            next_bit_rdata = source_gate_primary[bit_addr_i[2:0]];
        end else if (bit_addr_i[7:3] == `IEP_BITBASE_LEVEL_PRI) begin
            next_bit_rdata = level_select_primary[bit_addr_i[2:0]]
                             | (bit_addr_i[2:0] == 3'h7);
        end
    end

    // outputs: read data holds until the next read strobe
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sfr_rdata_o <= 8'h00;
            bit_rdata_o <= 1'b0;
            irq_req_o <= 1'b0;
            irq_vector_o <= 4'h0;
            irq_level_o <= 1'b0;
            in_service_low_o <= 1'b0;
            in_service_high_o <= 1'b0;
        end else if (ce_i) begin
            if (sfr_rd_i) begin
                sfr_rdata_o <= next_rdata;
            end
            if (bit_rd_i) begin
                bit_rdata_o <= next_bit_rdata;
            end
            // a fresh offer is withheld the cycle an ack is taken
            if (irq_ack_i && irq_req_o) begin
                irq_req_o <= 1'b0;
            end else begin
                irq_req_o <= next_req;
            end
            irq_vector_o <= next_vector;
            irq_level_o <= next_level;
            in_service_low_o <= next_in_low;
            in_service_high_o <= next_in_high;
        end
    end
endmodule // iep_irq_regs

// ==== iep_cpu_model.sv ====
// behavioural cpu core that takes offered vectors and returns from routines
`timescale 1ns/10ps
module iep_cpu_model (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic irq_req_i,
    input wire logic take_en_i,
    input wire logic [3:0] take_wait_i,
    input wire logic ret_cmd_i,
    output logic irq_ack_o,
    output logic irq_return_o
);
    logic [3:0] wait_cnt;

    // a slow core leaves the request standing for take_wait cycles before fetching
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wait_cnt <= 4'h0;
            irq_ack_o <= 1'b0;
            irq_return_o <= 1'b0;
        end else begin
            irq_return_o <= ret_cmd_i && !irq_return_o;
            irq_ack_o <= 1'b0;
            // no second ack right behind a taken one: the request drops for a cycle
            if (!irq_req_i || !take_en_i || irq_ack_o) begin
                wait_cnt <= 4'h0;
            end else if (wait_cnt >= take_wait_i) begin
                irq_ack_o <= 1'b1;
                wait_cnt <= 4'h0;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule // iep_cpu_model

// ==== iep_irq_regs_asserts.sv ====
// port-level checks of the interrupt enable and priority bank
`timescale 1ns/10ps
module iep_irq_regs_asserts (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic [7:0] bit_addr_i,
    input wire logic bit_wr_i,
    input wire logic bit_wdata_i,
    input wire logic irq_ack_i,
    input wire logic irq_return_i,
    input wire logic irq_req_o,
    input wire logic irq_level_o,
    input wire logic in_service_low_o,
    input wire logic in_service_high_o
);
    logic gate_q;

    // byte write wins over a bit write in the same cycle
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            gate_q <= 1'b0;
        end else if (ce_i && sfr_wr_i && sfr_addr_i == 8'hA8) begin
            gate_q <= sfr_wdata_i[7];
        end else if (ce_i && bit_wr_i && bit_addr_i == 8'hAF) begin
            gate_q <= bit_wdata_i;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    sequence s_take;
        ce_i && irq_ack_i && irq_req_o && !irq_return_i;
    endsequence
    sequence s_idle_ack;
        ce_i && irq_ack_i && !irq_req_o && !irq_return_i;
    endsequence

    chk_gate_closed: assert property (
        !gate_q && !$past(gate_q) && $past(ce_i) |-> !irq_req_o)
        else $error("request raised while the global gate is closed");
    chk_high_blocks: assert property (in_service_high_o |-> !irq_req_o)
        else $error("request raised during a high routine");
    chk_low_only_high: assert property (in_service_low_o && irq_req_o |-> irq_level_o)
        else $error("low request offered during a low routine");
    chk_ack_drops: assert property (s_take |=> !irq_req_o)
        else $error("request stays up after a taken ack");
    chk_ack_enters: assert property (s_take |=>
        ($past(irq_level_o) ? in_service_high_o : in_service_low_o))
        else $error("taken ack did not open a routine of its level");
    chk_ack_ignored: assert property (
        s_idle_ack |=> $stable({in_service_high_o, in_service_low_o}))
        else $error("ack without request changed the service state");
    chk_return_closes: assert property (
        ce_i && irq_return_i && !irq_ack_i && in_service_high_o
        |=> !in_service_high_o && in_service_low_o == $past(in_service_low_o))
        else $error("return did not close the high routine alone");
    chk_level_bit_one: assert property (
        ce_i && sfr_rd_i && sfr_addr_i == 8'hB8 |=> sfr_rdata_o[7])
        else $error("primary level bit 7 read as zero");
    chk_ext2_zeros: assert property (ce_i && sfr_rd_i && sfr_addr_i == 8'hE7
        |=> sfr_rdata_o[7:1] == 7'h00)
        else $error("second extended gate upper bits not zero");
endmodule // iep_irq_regs_asserts

bind iep_irq_regs iep_irq_regs_asserts iep_irq_regs_asserts_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o), .bit_addr_i(bit_addr_i), .bit_wr_i(bit_wr_i),
    .bit_wdata_i(bit_wdata_i), .irq_ack_i(irq_ack_i), .irq_return_i(irq_return_i),
    .irq_req_o(irq_req_o), .irq_level_o(irq_level_o), .in_service_low_o(in_service_low_o),
    .in_service_high_o(in_service_high_o)
);

// ==== iep_irq_regs_tb.sv ====
// self-checking bench for the interrupt enable and priority bank
`timescale 1ns/10ps
module iep_irq_regs_tb;
    logic clk_sys_i, rst_i, ce_i, sfr_wr_i, sfr_rd_i, bit_wr_i, bit_wdata_i, bit_rd_i, alt;
    logic irq_ack_i, irq_return_i, irq_req_o, irq_level_o, in_service_low_o, in_service_high_o;
    logic bit_rdata_o, take_en, ret_cmd;
    logic [7:0] sfr_addr_i, sfr_wdata_i, bit_addr_i, sfr_rdata_o;
    logic [3:0] irq_vector_o, take_wait;
    logic [15:0] p;
    logic [7:0] at [0:5] = '{8'hA8, 8'hB8, 8'hE6, 8'hE7, 8'hF6, 8'hF7};
    logic [7:0] sh [0:6] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    int err_total = 0;
    int num_checks = 0;

    iep_irq_regs iep_irq_regs_i (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i),
        .sfr_rdata_o(sfr_rdata_o), .bit_addr_i(bit_addr_i), .bit_wr_i(bit_wr_i),
        .bit_wdata_i(bit_wdata_i), .bit_rd_i(bit_rd_i), .bit_rdata_o(bit_rdata_o),
        .ext_in_a_i(p[0]), .timer0_overflow_i(p[1]), .ext_in_b_i(p[2]),
        .timer1_overflow_i(p[3]), .uart_req_i(p[4]), .timer2_low_overflow_i(p[5] & ~alt),
        .timer2_high_overflow_i(p[5] & alt), .spi_port_req_i(p[6]), .two_wire_req_i(p[7]),
        .usb_function_req_i(p[8]), .window_cmp_flag_i(p[9]), .conv_done_flag_i(p[10]),
        .counter_array_req_i(p[11]), .comparator_a_rise_flag_i(p[12] & ~alt),
        .comparator_a_fall_flag_i(p[12] & alt), .comparator_b_rise_flag_i(p[13] & alt),
        .comparator_b_fall_flag_i(p[13] & ~alt), .timer3_low_overflow_i(p[14] & ~alt),
        .timer3_high_overflow_i(p[14] & alt), .supply_sense_i(p[15]), .irq_ack_i(irq_ack_i),
        .irq_return_i(irq_return_i), .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o),
        .irq_level_o(irq_level_o), .in_service_low_o(in_service_low_o),
        .in_service_high_o(in_service_high_o)
    );

    iep_cpu_model iep_cpu_model_i (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .irq_req_i(irq_req_o), .take_en_i(take_en),
        .take_wait_i(take_wait), .ret_cmd_i(ret_cmd), .irq_ack_o(irq_ack_i),
        .irq_return_o(irq_return_i)
    );

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    function automatic int idx(input logic [7:0] a);
        for (int i = 0; i < 6; i++) begin
            if (at[i] == a) return i;
        end
        return 6;
    endfunction

    // one byte access; a write updates the shadow copy only when it is clocked in
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(negedge clk_sys_i);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = w;
        sfr_rd_i = !w;
        @(negedge clk_sys_i);
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b0;
        if (!w) check("register read", sh[idx(a)], sfr_rdata_o);
        else if (ce_i && idx(a) < 6) sh[idx(a)] = (d & (a[0] ? 8'h01 : 8'hFF))
            | (a == 8'hB8 ? 8'h80 : 8'h00);
    endtask

    task automatic bacc(input logic [7:0] ba, input logic v);
        @(negedge clk_sys_i);
        bit_addr_i = ba;
        bit_wdata_i = v;
        bit_wr_i = 1'b1;
        @(negedge clk_sys_i);
        bit_wr_i = 1'b0;
        bit_rd_i = 1'b1;
        if (ba[4] == 1'b0 || ba[2:0] != 3'h7) sh[ba[4]][ba[2:0]] = v;
        @(negedge clk_sys_i);
        bit_rd_i = 1'b0;
        check("bit read", {7'h00, sh[ba[4]][ba[2:0]]}, {7'h00, bit_rdata_o});
    endtask

    // expected winner from the shadow registers and the bench's own service state
    task automatic chk_irq(input logic isl, input logic ish);
        logic [15:0] en;
        logic [15:0] lv;
        logic [5:0] e;
        en = p & {sh[3][0], sh[2], sh[0][6:0]} & {16{sh[0][7]}};
        lv = {sh[5][0], sh[4], sh[1][6:0]};
        e = 6'h00;
        for (int i = 15; i >= 0; i--) begin
            if (en[i] && !lv[i] && !isl && !ish) e = {2'b10, 4'(i)};
        end
        for (int i = 15; i >= 0; i--) begin
            if (en[i] && lv[i] && !ish) e = {2'b11, 4'(i)};
        end
        check("irq request", {7'h00, e[5]}, {7'h00, irq_req_o});
        if (e[5]) check("irq vector", {3'h0, e[4:0]},
            {3'h0, irq_level_o, irq_vector_o});
    endtask

    task automatic wait_svc(input logic [1:0] want);
        int n = 0;
        while ({in_service_high_o, in_service_low_o} !== want && n < 40) begin
            @(negedge clk_sys_i);
            n++;
        end
        if ({in_service_high_o, in_service_low_o} !== want) begin
            err_total++;
            print_verdict();
        end else begin
            check("service state", {6'h00, want},
                {6'h00, in_service_high_o, in_service_low_o});
        end
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        {rst_i, ce_i} = 2'b11;
        {sfr_wr_i, sfr_rd_i, bit_wr_i, bit_wdata_i, bit_rd_i, alt, take_en, ret_cmd} = 8'h00;
        {sfr_addr_i, sfr_wdata_i, bit_addr_i} = 24'h000000;
        take_wait = 4'h0;
        p = 16'h0000;
        void'($urandom(64));
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_i = 1'b0;
        for (int i = 0; i < 7; i++) acc(i < 6 ? at[i] : 8'h3C, 8'h00, 1'b0);
        foreach (at[i]) begin
            acc(at[i], 8'hFF, 1'b1);
            acc(at[i], 8'h00, 1'b0);
            acc(at[i], 8'h00, 1'b1);
            acc(at[i], 8'h00, 1'b0);
        end
        ce_i = 1'b0;
        acc(8'hA8, 8'h55, 1'b1);
        ce_i = 1'b1;
        acc(8'hA8, 8'h00, 1'b0);
        bacc(8'hAF, 1'b1);
        bacc(8'hB8, 1'b1);
        bacc(8'hBF, 1'b0);
        // odd passes walk a single source so each mask and level bit is seen alone
        for (int n = 0; n < 400; n++) begin
            acc(at[$urandom_range(5)], 8'($urandom), 1'b1);
            p = n[0] ? 16'h0001 << n[7:4] : 16'($urandom);
            alt = 1'($urandom);
            @(negedge clk_sys_i);
            chk_irq(1'b0, 1'b0);
        end
        acc(8'hA8, 8'h83, 1'b1);
        acc(8'hB8, 8'h02, 1'b1);
        p = 16'h0001;
        take_wait = 4'h3;
        take_en = 1'b1;
        wait_svc(2'b01);
        take_en = 1'b0;
        @(negedge clk_sys_i);
        chk_irq(1'b1, 1'b0);
        p = 16'h0043;
        @(negedge clk_sys_i);
        chk_irq(1'b1, 1'b0);
        take_wait = 4'h0;
        take_en = 1'b1;
        wait_svc(2'b11);
        take_en = 1'b0;
        acc(8'hA8, 8'hC3, 1'b1);
        chk_irq(1'b1, 1'b1);
        ret_cmd = 1'b1;
        @(negedge clk_sys_i);
        ret_cmd = 1'b0;
        wait_svc(2'b01);
        @(negedge clk_sys_i);
        chk_irq(1'b1, 1'b0);
        p = 16'h0000;
        ret_cmd = 1'b1;
        @(negedge clk_sys_i);
        ret_cmd = 1'b0;
        wait_svc(2'b00);
        // one-cycle source pulse: the core's ack lands after the offer is gone
        take_en = 1'b1;
        p = 16'h0001;
        @(negedge clk_sys_i);
        p = 16'h0000;
        repeat (3) @(negedge clk_sys_i);
        take_en = 1'b0;
        wait_svc(2'b00);
        print_verdict();
    end
endmodule // iep_irq_regs_tb
